// ### pkg/rosm_defs.svh
// Behaviour
// - Restart valve purge on recovery if it ran.
// - Valve priority: reference, block, forced, purge, adjust, control.
// - Recovery value only without earlier non-reference priority.
// - Fresh control value replaces pending recovery value.
// - Automatic mode saves blind position, blind stays.
// - After recovery blind position object undefined.
// - Every reset acts as bus reset, no delays.
// - Bus reset: staircase loads, objects zero, contact opens.
// - Logic links saved, restored, unassigned off, reset keeps.
// - Fan-changing download performs full reset.
// - Plain download keeps objects, halts timers, holds contacts.
// - Unassigned disable-time object forced zero after download.
// - Plain download keeps switch state, staircase, permanent-on.
// - Bus failure allows one undelayed action per output.
// - Valve positions are unsigned 0 to 255.
// - Heat-up with higher target closes contact at once.
// - Base on-time is cycle over 255 times position.
// - Closing time adds scaled increment per stepped position.
// - After closing time, drive new PWM cycle afresh.
// - Cool-down with lower target opens contact at once.
// - PWM open time is value fraction of cycle.
`ifndef ROSM_DEFS_SVH
`define ROSM_DEFS_SVH
`define A_CTRL 8'h00
`define A_SRC 8'h04
`define A_VAL 8'h08
`define A_CVAL 8'h0c
`define A_TCYC 8'h10
`define A_TUP 8'h14
`define A_TDN 8'h18
`define A_SW 8'h1c
`define A_SWOBJ 8'h20
`define A_STCFG 8'h24
`define A_BLIND 8'h28
`define A_LINK 8'h2c
`define A_FAN 8'h30
`define A_STAT 8'h34
`define F_BUS_RST 8
`define F_DNLD 9
`define F_FAN_CHG 10
`define F_DIS_OBJ 16
`define F_PERM_OBJ 17
`define POS_MAX 8'hff
`define POS_REF 8'h00
`define POS_BLK 8'h00
`define POS_PRG 8'hff
`define TCYC_RST 16'h0384
`define TUP_RST 16'h00b4
`define TDN_RST 16'h00b4
`define STCFG_RST 16'h003c
`define CLK_NS 8
`define TICK_NS 1000000
`endif

// ### pkg/rosm_pkg.sv
package rosm_pkg;
    typedef enum logic [2:0] {
        V_PWM = 3'b001,
        V_UP = 3'b010,
        V_DN = 3'b100
    } vst_t;
    typedef struct packed {
        logic ref_mv;
        logic blk;
        logic frc;
        logic prg;
        logic adj;
    } vsrc_t;
    typedef struct packed {
        logic fan_off;
        logic rcv_en;
        logic lnk2_asg;
        logic lnk1_asg;
        logic dis_asg;
        logic auto_en;
    } cfg_t;
endpackage : rosm_pkg

// ### test/room_output_state_manager_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "rosm_defs.svh"
module room_output_state_manager_tb;
    localparam int P = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic drop = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] ad = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] q;
    wire logic bus_ok, valve, sw, waitreq;
    wire logic [31:0] rdata;
    wire logic [1:0] fan, lnk;
    wire logic [7:0] bpos;
    int vlen;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    room_output_state_manager #(.P_TICK_CYC(P)) DUT (.I_REF_CLK(clk), .I_SRST(srst),
        .I_CE(1'b1), .I_BUS_OK(bus_ok), .I_AVS_ADDRESS(ad), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .O_VALVE(valve), .O_SWITCH(sw), .O_FAN(fan),
        .O_BLIND_POS(bpos), .O_LINK(lnk));
    rosm_far far (.i_clk(clk), .i_drop(drop), .i_valve(valve), .o_bus_ok(bus_ok),
        .o_len(vlen));
    task end_of_test;
        if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task chk_in(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected at %0t: length %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_in
    // The request stands until a rising edge samples waitrequest low; only the
    // bench timeout ends a wait that never gets its answer.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task wrt(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wrt
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask : rdc
    task flip(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (valve === lvl && n < 2000);
        @(negedge clk);
    endtask : flip
    function automatic int tcalc(int c, int t, int a, int b);
        int s;
        s = 0;
        for (int v = a; v <= b; v++) s += v;
        tcalc = c * b / 255 + t * s / 65025;
        if (tcalc > t + c) tcalc = t + c;
    endfunction : tcalc
    task t_regs;
        rdc(`A_TCYC, 32'hffffffff, 32'h384);
        rdc(`A_TUP, 32'hffffffff, 32'hb4);
        rdc(`A_STCFG, 32'hffffffff, 32'h3c);
        rdc(`A_SWOBJ, 32'hffffffff, 32'h3c);
        rdc(8'hfc, 32'hffffffff, 32'h0);
    endtask : t_regs
    task t_prio;
        logic [7:0] pos [6];
        pos = '{8'h00, 8'h00, 8'h40, 8'hff, 8'h80, 8'h20};
        wrt(`A_TCYC, 32'h0a);
        wrt(`A_TUP, 32'h64);
        wrt(`A_TDN, 32'h64);
        wrt(`A_VAL, 32'h608040);
        wrt(`A_CVAL, 32'h20);
        for (int i = 0; i < 6; i++) begin
            wrt(`A_SRC, 32'h1f >> i);
            repeat (500) @(posedge clk);
            rdc(`A_STAT, 32'h1cff, ((i + 1) << 10) | pos[i]);
        end
    endtask : t_prio
    task t_fast;
        int e;
        wrt(`A_CVAL, 32'h0);
        repeat (500) @(posedge clk);
        wrt(`A_CVAL, 32'h80);
        repeat (2) @(negedge clk);
        chk(valve, 1'b1);
        flip(1'b1);
        e = (tcalc(10, 100, 0, 128) + 10 * 128 / 255) * P;
        chk_in(vlen, e - 2 * P - 2, e + 2 * P + 2);
        flip(1'b0);
        wrt(`A_CVAL, 32'h20);
        repeat (2) @(negedge clk);
        chk(valve, 1'b0);
        flip(1'b0);
        e = tcalc(10, 100, 127, 223) * P;
        chk_in(vlen, e - 2 * P - 2, e + 2 * P + 2);
        flip(1'b1);
        chk_in(vlen, 1, 2 * P + 1);
        flip(1'b0);
        e = (10 - 10 * 32 / 255) * P;
        chk_in(vlen, e - 2, e + 2);
    endtask : t_fast
    task t_fail;
        wrt(`A_CTRL, 32'h35);
        wrt(`A_LINK, 32'h3);
        wrt(`A_BLIND, 32'h55);
        wrt(`A_FAN, 32'h2);
        drop <= 1'b1;
        repeat (10) @(posedge clk);
        chk(fan, 2'h0);
        wrt(`A_BLIND, 32'h11);
        @(negedge clk);
        chk(bpos, 8'h55);
        drop <= 1'b0;
        repeat (10) @(posedge clk);
        rdc(`A_CVAL, 32'hff, 32'h60);
        chk(lnk, 2'h1);
        rdc(`A_BLIND, 32'h1ff, 32'h55);
        wrt(`A_BLIND, 32'h22);
        rdc(`A_BLIND, 32'h1ff, 32'h122);
        wrt(`A_CVAL, 32'h44);
        wrt(`A_SRC, 32'h2);
        drop <= 1'b1;
        repeat (10) @(posedge clk);
        wrt(`A_SRC, 32'h0);
        drop <= 1'b0;
        repeat (10) @(posedge clk);
        rdc(`A_SRC, 32'h1f, 32'h2);
        rdc(`A_CVAL, 32'hff, 32'h44);
        wrt(`A_CVAL, 32'h33);
        wrt(`A_SRC, 32'h0);
        repeat (5) @(posedge clk);
        rdc(`A_CVAL, 32'hff, 32'h33);
    endtask : t_fail
    task t_rst;
        wrt(`A_SWOBJ, 32'h20005);
        wrt(`A_SW, 32'h1);
        wrt(`A_CTRL, 32'h135);
        repeat (2) @(posedge clk);
        chk(sw, 1'b0);
        rdc(`A_SWOBJ, 32'h3ffff, 32'h3c);
        rdc(`A_CVAL, 32'hff, 32'h0);
        chk(lnk, 2'h1);
        wrt(`A_SWOBJ, 32'h10005);
        wrt(`A_SW, 32'h1);
        wrt(`A_CTRL, 32'h235);
        repeat (60) @(posedge clk);
        chk(sw, 1'b1);
        rdc(`A_SWOBJ, 32'h3ffff, 32'h5);
        wrt(`A_SWOBJ, 32'h10005);
        wrt(`A_CTRL, 32'h237);
        rdc(`A_SWOBJ, 32'h3ffff, 32'h10005);
        wrt(`A_CVAL, 32'h11);
        wrt(`A_FAN, 32'h2);
        wrt(`A_CTRL, 32'h635);
        repeat (2) @(posedge clk);
        chk({sw, fan}, 3'h0);
        rdc(`A_CVAL, 32'hff, 32'h0);
    endtask : t_rst
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_regs;
        t_prio;
        t_fast;
        t_fail;
        t_rst;
        end_of_test;
    end
endmodule : room_output_state_manager_tb
`default_nettype wire

// ### test/rosm_far.sv
`timescale 1ns/1ns
`default_nettype none
module rosm_far (
    input wire logic i_clk,
    input wire logic i_drop,
    input wire logic i_valve,
    output logic o_bus_ok,
    output int o_len
);
    int run = 0;
    logic last = 1'b0;
    // The supply is an ideal switch; the relay side only times each contact state.
    assign o_bus_ok = !i_drop;
    always_ff @(posedge i_clk) begin
        last <= i_valve;
        if (i_valve != last) begin
            o_len <= run;
            run <= 1;
        end else begin
            run <= run + 1;
        end
    end
endmodule : rosm_far
`default_nettype wire

// ### test/rosm_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "rosm_defs.svh"
module rosm_props (
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic I_BUS_OK,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [31:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_VALVE,
    input wire logic O_SWITCH,
    input wire logic [1:0] O_FAN,
    input wire logic [7:0] O_BLIND_POS,
    input wire logic [1:0] O_LINK
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SRST);
    wire logic req = I_AVS_READ || I_AVS_WRITE;
    sequence s_ctrl;
        I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == `A_CTRL;
    endsequence
    // Five cycles low lets the two-flop synchroniser report the failure first.
    sequence s_down;
        !I_BUS_OK [*5];
    endsequence
    wait_one_a: assert property (req && O_AVS_WAITREQUEST && I_CE ##1 req && I_CE
        |-> !O_AVS_WAITREQUEST) else $error("waitrequest held too long");
    idle_ready_a: assert property (!req |-> !O_AVS_WAITREQUEST)
        else $error("waitrequest without request");
    rst_safe_a: assert property ($fell(I_SRST) |-> !O_VALVE && !O_SWITCH
        && O_FAN == 2'h0 && O_LINK == 2'h0) else $error("outputs not safe after reset");
    bus_rst_a: assert property (s_ctrl ##0 I_AVS_WRITEDATA[8]
        |=> !O_VALVE && !O_SWITCH && O_FAN == 2'h0) else $error("bus reset left contacts");
    fan_dl_a: assert property (s_ctrl ##0 I_AVS_WRITEDATA[10:9] == 2'h3
        |=> !O_SWITCH && O_FAN == 2'h0) else $error("fan download left contacts");
    dl_keep_a: assert property (s_ctrl ##0 I_AVS_WRITEDATA[10:8] == 3'h2
        |=> $stable(O_SWITCH)) else $error("download moved switch");
    blind_hold_a: assert property (s_down |-> $stable(O_BLIND_POS))
        else $error("blind moved while bus down");
    fan_fail_a: assert property (s_down |-> $stable(O_FAN) || O_FAN == 2'h0)
        else $error("fan changed speed while bus down");
    unmapped_zero_a: assert property (I_AVS_READ && !O_AVS_WAITREQUEST
        && I_AVS_ADDRESS > `A_STAT |-> O_AVS_READDATA == 32'h0) else $error("unmapped read");
endmodule : rosm_props
bind room_output_state_manager rosm_props u_props (.I_REF_CLK(I_REF_CLK),
    .I_SRST(I_SRST), .I_CE(I_CE), .I_BUS_OK(I_BUS_OK), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .O_VALVE(O_VALVE), .O_SWITCH(O_SWITCH), .O_FAN(O_FAN), .O_BLIND_POS(O_BLIND_POS),
    .O_LINK(O_LINK));
`default_nettype wire

// ### verilog/room_output_state_manager.sv
`timescale 1ns/1ns
`default_nettype none
`include "rosm_defs.svh"
module room_output_state_manager #(
    parameter int unsigned P_TICK_CYC = `TICK_NS / `CLK_NS
) (
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic I_CE,
    input wire logic I_BUS_OK,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    output logic O_VALVE,
    output logic O_SWITCH,
    output logic [1:0] O_FAN,
    output logic [7:0] O_BLIND_POS,
    output logic [1:0] O_LINK
);

    // Pulse-width on-time: cycle over 255 times position.
    function automatic logic [17:0] on_time(input logic [15:0] tc,
                                            input logic [7:0] v);
        logic [23:0] p;
        p = 24'(tc) * 24'(v);
        on_time = 18'(p / 24'd255);
    endfunction : on_time

    // Sum of tt/255 * v/255 for v from a up to b, closed form.
    function automatic logic [17:0] travel(input logic [15:0] tt, input logic [7:0] a,
                                           input logic [7:0] b);
        logic [17:0] n;
        logic [33:0] p;
        n = (18'(a) + 18'(b)) * (18'(b) - 18'(a) + 18'h1);
        p = 34'(tt) * 34'(n >> 1);
        travel = 18'(p / 34'd65025);
    endfunction : travel

    function automatic logic [17:0] sat(input logic [17:0] t, input logic [17:0] lim);
        sat = (t > lim) ? lim : t;
    endfunction : sat

    logic bus_m_r, bus_s_r, bus_d_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [16:0] tick_cnt_r;
    rosm_pkg::cfg_t cfg_r;
    rosm_pkg::vsrc_t src_r;
    logic [7:0] frc_val_r, adj_val_r, rcv_val_r, ctrl_val_r;
    logic [15:0] tcyc_r, tup_r, tdn_r, stcfg_r, st_obj_r, st_cnt_r;
    logic dis_obj_r, perm_obj_r, sw_r, st_run_r;
    logic [7:0] blind_r, blind_sv_r;
    logic blind_ok_r;
    logic [1:0] link_r, link_sv_r, fan_r;
    logic purge_was_r, prio_was_r, rcv_pend_r;
    rosm_pkg::vst_t vst_r;
    logic [7:0] pos_r;
    logic [17:0] fast_r;
    logic [15:0] pwm_r;
    logic valve_r;

    wire logic req = I_AVS_READ | I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = req & ~(ack_r & I_CE);
    wire logic wr_go = I_AVS_WRITE & ack_r;
    wire logic [31:0] wd = I_AVS_WRITEDATA;
    wire logic w_ctrl = wr_go & (I_AVS_ADDRESS == `A_CTRL);
    wire logic w_src = wr_go & (I_AVS_ADDRESS == `A_SRC);
    wire logic w_val = wr_go & (I_AVS_ADDRESS == `A_VAL);
    wire logic w_cval = wr_go & (I_AVS_ADDRESS == `A_CVAL);
    wire logic w_tcyc = wr_go & (I_AVS_ADDRESS == `A_TCYC);
    wire logic w_tup = wr_go & (I_AVS_ADDRESS == `A_TUP);
    wire logic w_tdn = wr_go & (I_AVS_ADDRESS == `A_TDN);
    wire logic w_sw = wr_go & (I_AVS_ADDRESS == `A_SW);
    wire logic w_swobj = wr_go & (I_AVS_ADDRESS == `A_SWOBJ);
    wire logic w_stcfg = wr_go & (I_AVS_ADDRESS == `A_STCFG);
    wire logic w_blind = wr_go & (I_AVS_ADDRESS == `A_BLIND);
    wire logic w_link = wr_go & (I_AVS_ADDRESS == `A_LINK);
    wire logic w_fan = wr_go & (I_AVS_ADDRESS == `A_FAN);

    // Software resets and downloads arrive as one-shot bits of the control word.
    wire logic bus_rst = w_ctrl & wd[`F_BUS_RST];
    wire logic dnld = w_ctrl & wd[`F_DNLD];
    wire logic full_rst = bus_rst | (dnld & wd[`F_FAN_CHG]);
    wire logic plain_dnld = dnld & ~wd[`F_FAN_CHG];
    // A plain download keeps the disable-time object only if the same word marks it assigned.
    wire logic dis_keep = wd[1];

    // Edges of the synchronised bus voltage; the third flop only holds the last level.
    wire logic fail_ev = bus_d_r & ~bus_s_r;
    wire logic rec_ev = ~bus_d_r & bus_s_r;
    wire logic bus_up = bus_s_r;
    wire logic tick = (tick_cnt_r == 17'(P_TICK_CYC - 1));

    // Telegrams to the contacts count only while the bus voltage is present.
    wire logic sw_tel = w_sw & bus_up;
    wire logic blind_tel = w_blind & bus_up;
    wire logic fan_tel = w_fan & bus_up;
    // The staircase timer runs on the tick and stands still while the bus is down.
    wire logic st_expire = st_run_r & tick & bus_up;
    wire logic st_last = (st_cnt_r <= 16'h1);

    // Fixed priority, re-decided combinationally on every source change.
    wire logic prio_now = src_r.blk | src_r.frc | src_r.prg | src_r.adj;
    wire logic [7:0] tgt = src_r.ref_mv ? `POS_REF :
                           src_r.blk ? `POS_BLK :
                           src_r.frc ? frc_val_r :
                           src_r.prg ? `POS_PRG :
                           src_r.adj ? adj_val_r : ctrl_val_r;
    wire logic [2:0] act_src = src_r.ref_mv ? 3'h1 :
                               src_r.blk ? 3'h2 :
                               src_r.frc ? 3'h3 :
                               src_r.prg ? 3'h4 :
                               src_r.adj ? 3'h5 : 3'h6;

    wire logic [17:0] up_lim = 18'(tup_r) + 18'(tcyc_r);
    wire logic [17:0] dn_lim = 18'(tdn_r) + 18'(tcyc_r);
    wire logic [17:0] up_base = on_time(tcyc_r, tgt);
    wire logic [17:0] up_trav = travel(tup_r, pos_r, tgt);
    wire logic [17:0] up_t = sat(up_base + up_trav, up_lim);
    // Cool-down mirrors heat-up on the inverted scale, 255 minus the position.
    wire logic [17:0] dn_base = on_time(tcyc_r, ~tgt);
    wire logic [17:0] dn_trav = travel(tdn_r, ~pos_r, ~tgt);
    wire logic [17:0] dn_t = sat(dn_base + dn_trav, dn_lim);
    wire logic go_up = (tgt > pos_r);
    wire logic go_dn = (tgt < pos_r);
    wire logic fast_done = (fast_r == 18'h0);
    // A zero cycle length keeps the counter parked at zero instead of running wild.
    wire logic [17:0] pwm_on = on_time(tcyc_r, pos_r);
    wire logic pwm_wrap = (pwm_r >= tcyc_r - 16'h1) | (tcyc_r == 16'h0);

    // Status word: position, contacts, active source, valve state, blind validity.
    wire logic [31:0] stat = {
        15'h0,
        blind_ok_r,
        vst_r,
        act_src,
        sw_r,
        valve_r,
        pos_r
    };
    logic [31:0] rmux;
    always_comb begin
        case (I_AVS_ADDRESS)
            `A_CTRL: rmux = {26'h0, cfg_r};
            `A_SRC: rmux = {27'h0, src_r};
            `A_VAL: rmux = {8'h0, rcv_val_r, adj_val_r, frc_val_r};
            `A_CVAL: rmux = {24'h0, ctrl_val_r};
            `A_TCYC: rmux = {16'h0, tcyc_r};
            `A_TUP: rmux = {16'h0, tup_r};
            `A_TDN: rmux = {16'h0, tdn_r};
            `A_SW: rmux = {31'h0, sw_r};
            `A_SWOBJ: rmux = {14'h0, perm_obj_r, dis_obj_r, st_obj_r};
            `A_STCFG: rmux = {16'h0, stcfg_r};
            `A_BLIND: rmux = {23'h0, blind_ok_r, blind_r};
            `A_LINK: rmux = {30'h0, link_r};
            `A_FAN: rmux = {30'h0, fan_r};
            `A_STAT: rmux = stat;
            default: rmux = 32'h0;
        endcase
    end

    // Bus voltage is a pin, so it passes two flops before any logic sees it.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            bus_m_r <= 1'b0;
            bus_s_r <= 1'b0;
            bus_d_r <= 1'b0;
        end else if (I_CE) begin
            bus_m_r <= I_BUS_OK;
            bus_s_r <= bus_m_r;
            bus_d_r <= bus_s_r;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
            tick_cnt_r <= 17'h0;
        end else if (I_CE) begin
            ack_r <= req & ~ack_r;
            if (I_AVS_READ & ~ack_r) begin
                rdata_r <= rmux;
            end
            tick_cnt_r <= tick ? 17'h0 : tick_cnt_r + 17'h1;
        end
    end

    // Configuration survives bus resets; only the reset pin returns it to defaults.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            cfg_r <= '0;
            frc_val_r <= 8'h0;
            adj_val_r <= 8'h0;
            rcv_val_r <= 8'h0;
            tcyc_r <= `TCYC_RST;
            tup_r <= `TUP_RST;
            tdn_r <= `TDN_RST;
            stcfg_r <= `STCFG_RST;
        end else if (I_CE) begin
            if (w_ctrl) cfg_r <= rosm_pkg::cfg_t'(wd[5:0]);
            if (w_val) begin
                frc_val_r <= wd[7:0];
                adj_val_r <= wd[15:8];
                rcv_val_r <= wd[23:16];
            end
            if (w_tcyc) tcyc_r <= wd[15:0];
            if (w_tup) tup_r <= wd[15:0];
            if (w_tdn) tdn_r <= wd[15:0];
            if (w_stcfg) stcfg_r <= wd[15:0];
        end
    end

    // Valve sources, control value and the bus-failure snapshot.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST | (I_CE & full_rst)) begin
            src_r <= '0;
            ctrl_val_r <= 8'h0;
            purge_was_r <= 1'b0;
            prio_was_r <= 1'b0;
            rcv_pend_r <= 1'b0;
        end else if (I_CE) begin
            if (w_src) src_r <= rosm_pkg::vsrc_t'(wd[4:0]);
            if (fail_ev) begin
                purge_was_r <= src_r.prg;
                prio_was_r <= prio_now;
            end
            if (rec_ev) begin
                src_r.prg <= purge_was_r;
                if (cfg_r.rcv_en & ~prio_was_r) begin
                    ctrl_val_r <= rcv_val_r;
                end
                rcv_pend_r <= cfg_r.rcv_en & prio_was_r;
            end else if (rcv_pend_r & ~prio_now) begin
                ctrl_val_r <= rcv_val_r;
                rcv_pend_r <= 1'b0;
            end
            if (w_cval) begin
                ctrl_val_r <= wd[7:0];
                rcv_pend_r <= 1'b0;
            end
        end
    end

    // Switch output with its staircase timer and objects.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            sw_r <= 1'b0;
            st_obj_r <= `STCFG_RST;
            dis_obj_r <= 1'b0;
            perm_obj_r <= 1'b0;
            st_run_r <= 1'b0;
            st_cnt_r <= 16'h0;
        end else if (I_CE) begin
            if (full_rst) begin
                st_obj_r <= stcfg_r;
                dis_obj_r <= 1'b0;
                perm_obj_r <= 1'b0;
                sw_r <= 1'b0;
                st_run_r <= 1'b0;
                st_cnt_r <= 16'h0;
            end else if (plain_dnld) begin
                st_run_r <= 1'b0;
                if (~dis_keep) dis_obj_r <= 1'b0;
            end else begin
                if (w_swobj) begin
                    st_obj_r <= wd[15:0];
                    dis_obj_r <= wd[`F_DIS_OBJ];
                    perm_obj_r <= wd[`F_PERM_OBJ];
                end
                // A contact held over a download moves only on a switch telegram.
                if (sw_tel) begin
                    sw_r <= wd[0];
                    st_run_r <= wd[0] & (st_obj_r != 16'h0);
                    st_cnt_r <= st_obj_r;
                end else if (st_expire) begin
                    if (st_last) begin
                        st_run_r <= 1'b0;
                        if (~dis_obj_r & ~perm_obj_r) sw_r <= 1'b0;
                    end else begin
                        st_cnt_r <= st_cnt_r - 16'h1;
                    end
                end
            end
        end
    end

    // Blind, logic links and fan.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            blind_r <= 8'h0;
            blind_sv_r <= 8'h0;
            blind_ok_r <= 1'b0;
            link_r <= 2'h0;
            link_sv_r <= 2'h0;
            fan_r <= 2'h0;
        end else if (I_CE) begin
            if (fail_ev & cfg_r.auto_en) blind_sv_r <= blind_r;
            if (fail_ev) link_sv_r <= link_r;
            if (rec_ev) begin
                if (cfg_r.auto_en) blind_r <= blind_sv_r;
                blind_ok_r <= 1'b0;
                link_r <= link_sv_r & {cfg_r.lnk2_asg, cfg_r.lnk1_asg};
            end
            // A motion telegram in the recovery cycle still marks the position valid.
            if (blind_tel) begin
                blind_r <= wd[7:0];
                blind_ok_r <= 1'b1;
            end
            if (w_link & ~rec_ev) link_r <= wd[1:0];
            if (full_rst) fan_r <= 2'h0;
            else if (fail_ev & cfg_r.fan_off) fan_r <= 2'h0;
            else if (fan_tel) fan_r <= wd[1:0];
        end
    end

    // Valve drive: fast heat-up, fast cool-down, then plain PWM.
    always_ff @(posedge I_REF_CLK) begin
        if (I_SRST | (I_CE & full_rst)) begin
            vst_r <= rosm_pkg::V_PWM;
            pos_r <= 8'h0;
            fast_r <= 18'h0;
            pwm_r <= 16'h0;
            valve_r <= 1'b0;
        end else if (I_CE & bus_up) begin
            case (vst_r)
                rosm_pkg::V_PWM: begin
                    if (go_up) begin
                        vst_r <= rosm_pkg::V_UP;
                        fast_r <= up_t;
                        pos_r <= tgt;
                        valve_r <= 1'b1;
                    end else if (go_dn) begin
                        vst_r <= rosm_pkg::V_DN;
                        fast_r <= dn_t;
                        pos_r <= tgt;
                        valve_r <= 1'b0;
                    end else begin
                        if (tick) pwm_r <= pwm_wrap ? 16'h0 : pwm_r + 16'h1;
                        valve_r <= (pos_r == `POS_MAX) | (18'(pwm_r) < pwm_on);
                    end
                end
                rosm_pkg::V_UP, rosm_pkg::V_DN: begin
                    if (fast_done) begin
                        vst_r <= rosm_pkg::V_PWM;
                        pwm_r <= 16'h0;
                        valve_r <= (pos_r == `POS_MAX) | (pwm_on != 18'h0);
                    end else if (tick) begin
                        fast_r <= fast_r - 18'h1;
                    end
                end
                default: begin
                    vst_r <= rosm_pkg::V_PWM;
                end
            endcase
        end
    end

    // Outputs other than O_LINK freeze while the bus is down: the one undelayed action is already taken.
    assign O_VALVE = valve_r;
    assign O_SWITCH = sw_r;
    assign O_FAN = fan_r;
    assign O_BLIND_POS = blind_r;
    assign O_LINK = link_r;
    assign O_AVS_READDATA = rdata_r;

endmodule : room_output_state_manager
`default_nettype wire
